// >>> drc_regs.svh
/*
  Constants shared by the controller end and the device end of the DDR2 link:
  command codes, mode register fields, burst and timing counts.
  Assumes it is included by its bare name into each file that uses its constants.
*/
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH

// command code {cs_n, ras_n, cas_n, we_n}
`define DRC_CMD_MRS 4'h0
`define DRC_CMD_REF 4'h1
`define DRC_CMD_PRE 4'h2
`define DRC_CMD_ACT 4'h3
`define DRC_CMD_WR 4'h4
`define DRC_CMD_RD 4'h5
`define DRC_CMD_NOP 4'h7

`define DRC_A10_BIT 10
`define DRC_EMR_IDX 2'h1
`define DRC_EMR_RTT0_BIT 2
`define DRC_EMR_RTT1_BIT 6
`define DRC_EMR_DQSN_DIS_BIT 10
`define DRC_MR_RESET 15'h0000

`define DRC_BURST 8'h04
`define DRC_READ_LAT 2
`define DRC_LINK_PERIOD_NS 48
`define DRC_SYS_PERIOD_NS 4
`define DRC_CK_HALF_CYC ((`DRC_LINK_PERIOD_NS / `DRC_SYS_PERIOD_NS) / 2)

`endif

// >>> drc_pkg.sv
/*
  Types of the DDR2 link ends: power state of a rank and controller states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package drc_pkg;
  typedef enum logic [1:0] {
    DRC_PWR_ACTIVE,
    DRC_PWR_PD_PRE,
    DRC_PWR_PD_ACT,
    DRC_PWR_SREF
  } drc_pwr_t;

  typedef enum logic [1:0] {
    DRC_C_IDLE,
    DRC_C_CMD,
    DRC_C_WR,
    DRC_C_RD
  } drc_ctl_st_t;
endpackage

// >>> drc_link_if.sv
/*
  Pin bundle between the memory controller and the two ranks of the device.
  Resolves the two-way data, strobe and complement strobe wires from the
  output enables; an undriven wire reads as zero.
*/
`timescale 1ns/1ns
`default_nettype none
interface drc_link_if #(
  parameter int DQ_W = 8
);
  logic ck;
  logic [1:0] cke;
  logic [1:0] cs_n;
  logic [1:0] odt;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [14:0] addr;
  logic dm;
  logic [DQ_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic ctl_dqs;
  logic ctl_dqs_n;
  logic ctl_dqs_oe;
  logic [DQ_W-1:0] dev_dq [2];
  logic dev_dq_oe [2];
  logic dev_dqs [2];
  logic dev_dqs_oe [2];
  logic dev_dqs_n [2];
  logic dev_dqsn_oe [2];
  logic [DQ_W-1:0] dq;
  logic dqs;
  logic dqs_n;

  always_comb begin
    dq = ctl_dq_oe ? ctl_dq : '0;
    dqs = ctl_dqs_oe ? ctl_dqs : 1'b0;
    dqs_n = ctl_dqs_oe ? ctl_dqs_n : 1'b0;
    for (int r = 0; r < 2; r++) begin
      if (dev_dq_oe[r]) begin
        dq = dev_dq[r];
      end
      if (dev_dqs_oe[r]) begin
        dqs = dev_dqs[r];
      end
      if (dev_dqsn_oe[r]) begin
        dqs_n = dev_dqs_n[r];
      end
    end
  end

  modport ctl (
    output ck, cke, cs_n, odt, ras_n, cas_n, we_n, ba, addr, dm,
    output ctl_dq, ctl_dq_oe, ctl_dqs, ctl_dqs_n, ctl_dqs_oe,
    input dq, dqs, dqs_n
  );
  modport dev (
    input ck, cke, cs_n, odt, ras_n, cas_n, we_n, ba, addr, dm,
    input dq, dqs, dqs_n,
    output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe, dev_dqs_n, dev_dqsn_oe
  );
endinterface
`default_nettype wire

// >>> drc_dev.sv
/*
  Device end: one rank of the dual-rank DDR2 memory, with clock enable power
  states, chip-select masked command decoding, masked writes, termination and
  strobed reads, and a small data store. Runs on the link clock, except self refresh exit, which follows the enable pin.
  Assumes the controller changes pins half a link period before each rising
  edge and places write strobe edges inside each data beat.
*/
`timescale 1ns/1ns
`default_nettype none
`include "drc_regs.svh"
module drc_dev #(
  parameter int RANK = 0,
  parameter int DQ_W = 8,
  parameter int RL = `DRC_READ_LAT,
  parameter int COL_W = 4
) (
  drc_link_if.dev LINK,
  input wire logic RST_N_I,
  output logic [1:0] PWR_STATE_O,
  output logic CLK_ON_O,
  output logic TERM_ON_O,
  output logic DIFF_DQS_O,
  output logic [7:0] BANK_OPEN_O
);
  localparam int AW = 3 + COL_W;

  if (!(DQ_W == 4 || DQ_W == 8)) begin : g_bad_width
    $error("data width must be 4 or 8");
  end
  if (RANK < 0 || RANK > 1 || RL < 1 || RL > 32 || COL_W < 2 || COL_W > 10) begin : g_bad_param
    $error("rank, read latency or column width out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic ck;
  logic cke_pin;
  logic odt_pin;
  logic cs_n_pin;
  logic [3:0] cmd;
  assign ck = LINK.ck;
  assign cke_pin = LINK.cke[RANK];
  assign odt_pin = LINK.odt[RANK];
  assign cs_n_pin = LINK.cs_n[RANK];
  assign cmd = {cs_n_pin, LINK.ras_n, LINK.cas_n, LINK.we_n};

  drc_pkg::drc_pwr_t pwr_reg, pwr_next;
  logic sref_reg, sref_next;
  logic cke_reg, cke_next;
  logic odt_reg, odt_next;
  logic [7:0] open_reg, open_next;
  logic [14:0] mr_reg [4];
  logic [14:0] mr_next [4];
  logic [7:0] wr_cnt_reg, wr_cnt_next;
  logic [AW-1:0] wr_addr_reg, wr_addr_next;
  logic dqs_seen_reg, dqs_seen_next;
  logic [7:0] rd_cnt_reg, rd_cnt_next;
  logic [AW-1:0] rd_addr_reg, rd_addr_next;
  logic [DQ_W-1:0] dq_out_reg, dq_out_next;
  logic dqs_out_reg, dqs_out_next;
  logic drive_reg, drive_next;
  logic mem_we;
  logic [1:0] beat;
  logic [DQ_W-1:0] mem [2**AW];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pwr_next = pwr_reg;
    sref_next = sref_reg;
    cke_next = cke_reg;
    odt_next = odt_reg;
    open_next = open_reg;
    mr_next = mr_reg;
    wr_cnt_next = wr_cnt_reg;
    wr_addr_next = wr_addr_reg;
    dqs_seen_next = dqs_seen_reg;
    rd_cnt_next = rd_cnt_reg;
    rd_addr_next = rd_addr_reg;
    mem_we = 1'b0;
    // self refresh: nothing but the async enable path is looked at
    if (!sref_reg) begin
      cke_next = cke_pin;
      odt_next = odt_pin;
      if (pwr_reg == drc_pkg::DRC_PWR_ACTIVE) begin
        dqs_seen_next = LINK.dqs;
        // a write beat is one strobe edge, the mask rides with it
        if (wr_cnt_reg != 8'h00 && LINK.dqs != dqs_seen_reg) begin
          mem_we = !LINK.dm;
          wr_cnt_next = wr_cnt_reg - 8'h01;
          wr_addr_next = {wr_addr_reg[AW-1:2], 2'(wr_addr_reg[1:0] + 2'h1)};
        end
        if (rd_cnt_reg != 8'h00) begin
          rd_cnt_next = rd_cnt_reg - 8'h01;
        end
        if (cke_reg && !cke_pin) begin
          // entry decided at the edge that first samples the enable low
          if (cmd == `DRC_CMD_REF && open_reg == 8'h00) begin
            sref_next = 1'b1;
          end else if (|open_reg) begin
            pwr_next = drc_pkg::DRC_PWR_PD_ACT;
          end else begin
            pwr_next = drc_pkg::DRC_PWR_PD_PRE;
          end
        end else if (cke_reg && cke_pin && !cs_n_pin) begin
          case (cmd)
            `DRC_CMD_ACT: begin
              open_next[LINK.ba] = 1'b1;
            end
            `DRC_CMD_PRE: begin
              if (LINK.addr[`DRC_A10_BIT]) begin
                open_next = 8'h00;
              end else begin
                open_next[LINK.ba] = 1'b0;
              end
            end
            `DRC_CMD_MRS: begin
              if (!LINK.ba[2]) begin
                mr_next[LINK.ba[1:0]] = LINK.addr;
              end
            end
            `DRC_CMD_WR: begin
              wr_cnt_next = `DRC_BURST;
              wr_addr_next = {LINK.ba, LINK.addr[COL_W-1:0]};
            end
            `DRC_CMD_RD: begin
              rd_cnt_next = 8'(RL) + `DRC_BURST;
              rd_addr_next = {LINK.ba, LINK.addr[COL_W-1:0]};
            end
            default: begin
            end
          endcase
        end
      end else if (cke_pin) begin
        pwr_next = drc_pkg::DRC_PWR_ACTIVE;
      end
    end
  end

  // read beats: data and strobe leave on the same edge
  always_comb begin
    drive_next = (rd_cnt_next != 8'h00) && (rd_cnt_next <= `DRC_BURST);
    beat = 2'(`DRC_BURST - rd_cnt_next);
    dq_out_next = dq_out_reg;
    dqs_out_next = 1'b0;
    if (drive_next) begin
      dq_out_next = mem[{rd_addr_next[AW-1:2], 2'(rd_addr_next[1:0] + beat)}];
      dqs_out_next = !dqs_out_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ck) begin
    if (!RST_N_I) begin
      pwr_reg <= drc_pkg::DRC_PWR_ACTIVE;
      cke_reg <= 1'b0;
      odt_reg <= 1'b0;
      open_reg <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        mr_reg[i] <= `DRC_MR_RESET;
      end
      wr_cnt_reg <= 8'h00;
      wr_addr_reg <= '0;
      dqs_seen_reg <= 1'b0;
      rd_cnt_reg <= 8'h00;
      rd_addr_reg <= '0;
      dq_out_reg <= '0;
      dqs_out_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      cke_reg <= cke_next;
      odt_reg <= odt_next;
      open_reg <= open_next;
      mr_reg <= mr_next;
      wr_cnt_reg <= wr_cnt_next;
      wr_addr_reg <= wr_addr_next;
      dqs_seen_reg <= dqs_seen_next;
      rd_cnt_reg <= rd_cnt_next;
      rd_addr_reg <= rd_addr_next;
      dq_out_reg <= dq_out_next;
      dqs_out_reg <= dqs_out_next;
      drive_reg <= drive_next;
    end
  end

  // the link clock may be stopped in self refresh, so exit cannot wait for it
  always_ff @(posedge ck or posedge cke_pin) begin
    if (cke_pin) begin
      sref_reg <= 1'b0;
    end else if (!RST_N_I) begin
      sref_reg <= 1'b0;
    end else begin
      sref_reg <= sref_next;
    end
  end

  always_ff @(posedge ck) begin
    if (mem_we) begin
      mem[wr_addr_reg] <= LINK.dq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign PWR_STATE_O = sref_reg ? drc_pkg::DRC_PWR_SREF : pwr_reg;
  assign CLK_ON_O = cke_reg && !sref_reg;
  assign TERM_ON_O = odt_reg && !sref_reg &&
    (mr_reg[`DRC_EMR_IDX][`DRC_EMR_RTT0_BIT] || mr_reg[`DRC_EMR_IDX][`DRC_EMR_RTT1_BIT]);
  assign DIFF_DQS_O = !mr_reg[`DRC_EMR_IDX][`DRC_EMR_DQSN_DIS_BIT];
  assign BANK_OPEN_O = open_reg;

  assign LINK.dev_dq[RANK] = dq_out_reg;
  assign LINK.dev_dq_oe[RANK] = drive_reg;
  assign LINK.dev_dqs[RANK] = dqs_out_reg;
  assign LINK.dev_dqs_oe[RANK] = drive_reg;
  assign LINK.dev_dqs_n[RANK] = !dqs_out_reg;
  assign LINK.dev_dqsn_oe[RANK] = drive_reg && DIFF_DQS_O;
endmodule
`default_nettype wire

// >>> drc_ctrl.sv
/*
  Controller end: makes the link clock by dividing SYS_CLK_I, issues one
  command per request to the selected rank (none for a self refresh with a row
  open), drives write bursts with a strobe edge a quarter beat in and gathers read bursts.
  Assumes requests come from logic on SYS_CLK_I and the device ranks answer
  reads within the read latency it was built with.
*/
`timescale 1ns/1ns
`default_nettype none
`include "drc_regs.svh"
module drc_ctrl #(
  parameter int DQ_W = 8,
  parameter int HALF = `DRC_CK_HALF_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  drc_link_if.ctl LINK,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic [3:0] REQ_CMD_I,
  input wire logic REQ_RANK_I,
  input wire logic [2:0] REQ_BA_I,
  input wire logic [14:0] REQ_ADDR_I,
  input wire logic [4*DQ_W-1:0] REQ_WDATA_I,
  input wire logic [3:0] REQ_WMASK_I,
  input wire logic [1:0] CKE_I,
  input wire logic [1:0] ODT_I,
  output logic RD_VALID_O,
  output logic [4*DQ_W-1:0] RD_DATA_O
);
  if (!(DQ_W == 4 || DQ_W == 8) || HALF < 2 || HALF > 127) begin : g_bad_param
    $error("data width or clock divider out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  drc_pkg::drc_ctl_st_t st_reg, st_next;
  logic [7:0] div_reg, div_next;
  logic ck_reg, ck_next;
  logic [1:0] cke_reg, cke_next, odt_reg, odt_next, cs_n_reg, cs_n_next;
  logic [3:0] cmd_reg, cmd_next;
  logic [2:0] ba_reg, ba_next;
  logic [14:0] addr_reg, addr_next;
  logic [4*DQ_W-1:0] wdata_reg, wdata_next, rbuf_reg, rbuf_next, rd_data_reg, rd_data_next;
  logic [3:0] wmask_reg, wmask_next;
  logic [1:0] beat_reg, beat_next;
  logic [7:0] open_reg [2];
  logic [7:0] open_next [2];
  logic dq_oe_reg, dq_oe_next, dqs_reg, dqs_next, rd_valid_reg, rd_valid_next;
  logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg;
  logic dqs_s1_reg, dqs_s2_reg, dqs_seen_reg;
  logic fall_evt, mid_evt;

  assign fall_evt = (div_reg == 8'(HALF - 1));
  assign mid_evt = (div_reg == 8'(HALF + HALF / 2 - 1));
  assign REQ_READY_O = (st_reg == drc_pkg::DRC_C_IDLE) && fall_evt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    div_next = (div_reg == 8'(2 * HALF - 1)) ? 8'h00 : div_reg + 8'h01;
    ck_next = (div_next < 8'(HALF));
    {cke_next, odt_next, cs_n_next, cmd_next} = {cke_reg, odt_reg, cs_n_reg, cmd_reg};
    {ba_next, addr_next, wdata_next, wmask_next} = {ba_reg, addr_reg, wdata_reg, wmask_reg};
    beat_next = beat_reg;
    open_next = open_reg;
    dq_oe_next = dq_oe_reg;
    dqs_next = dqs_reg;
    rbuf_next = rbuf_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    // pins move with the falling link clock, half a period before sampling
    if (fall_evt) begin
      cke_next = CKE_I;
      odt_next = ODT_I;
      cs_n_next = 2'h3;
      cmd_next = `DRC_CMD_NOP;
      case (st_reg)
        drc_pkg::DRC_C_IDLE: begin
          if (REQ_VALID_I) begin
            st_next = drc_pkg::DRC_C_CMD;
            cmd_next = {1'b0, REQ_CMD_I[2:0]};
            ba_next = REQ_BA_I;
            addr_next = REQ_ADDR_I;
            wdata_next = REQ_WDATA_I;
            wmask_next = REQ_WMASK_I;
            cs_n_next[REQ_RANK_I] = 1'b0;
            // self refresh with a row open is not sent
            if (REQ_CMD_I == `DRC_CMD_REF && !CKE_I[REQ_RANK_I] && |open_reg[REQ_RANK_I]) begin
              cs_n_next = 2'h3;
              cmd_next = `DRC_CMD_NOP;
            end else if (REQ_CMD_I == `DRC_CMD_ACT) begin
              open_next[REQ_RANK_I][REQ_BA_I] = 1'b1;
            end else if (REQ_CMD_I == `DRC_CMD_PRE) begin
              if (REQ_ADDR_I[`DRC_A10_BIT]) begin
                open_next[REQ_RANK_I] = 8'h00;
              end else begin
                open_next[REQ_RANK_I][REQ_BA_I] = 1'b0;
              end
            end
          end
        end
        drc_pkg::DRC_C_CMD: begin
          beat_next = 2'h0;
          if (cmd_reg == `DRC_CMD_WR) begin
            st_next = drc_pkg::DRC_C_WR;
            dq_oe_next = 1'b1;
            dqs_next = 1'b0;
          end else if (cmd_reg == `DRC_CMD_RD) begin
            st_next = drc_pkg::DRC_C_RD;
          end else begin
            st_next = drc_pkg::DRC_C_IDLE;
          end
        end
        drc_pkg::DRC_C_WR: begin
          if (beat_reg == 2'h3) begin
            st_next = drc_pkg::DRC_C_IDLE;
            dq_oe_next = 1'b0;
          end else begin
            beat_next = beat_reg + 2'h1;
          end
        end
        default: begin
        end
      endcase
    end
    // strobe edge a quarter of the way through each write beat, half way to the rising edge
    if (mid_evt && st_reg == drc_pkg::DRC_C_WR) begin
      dqs_next = !dqs_reg;
    end
    if (st_reg == drc_pkg::DRC_C_RD && dqs_s2_reg != dqs_seen_reg) begin
      rbuf_next = {dq_s2_reg, rbuf_reg[4*DQ_W-1:DQ_W]};
      beat_next = beat_reg + 2'h1;
      if (beat_reg == 2'h3) begin
        rd_data_next = {dq_s2_reg, rbuf_reg[4*DQ_W-1:DQ_W]};
        rd_valid_next = 1'b1;
        st_next = drc_pkg::DRC_C_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      st_reg <= drc_pkg::DRC_C_IDLE;
      div_reg <= 8'h00;
      ck_reg <= 1'b0;
      {cke_reg, odt_reg, cs_n_reg, cmd_reg} <= {2'h0, 2'h0, 2'h3, `DRC_CMD_NOP};
      {ba_reg, addr_reg, wmask_reg, beat_reg} <= '0;
      wdata_reg <= '0;
      open_reg[0] <= 8'h00;
      open_reg[1] <= 8'h00;
      {dq_oe_reg, dqs_reg, rd_valid_reg} <= 3'h0;
      rbuf_reg <= '0;
      rd_data_reg <= '0;
      {dq_s1_reg, dq_s2_reg} <= '0;
      {dqs_s1_reg, dqs_s2_reg, dqs_seen_reg} <= 3'h0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      ck_reg <= ck_next;
      {cke_reg, odt_reg, cs_n_reg, cmd_reg} <= {cke_next, odt_next, cs_n_next, cmd_next};
      {ba_reg, addr_reg, wmask_reg, beat_reg} <= {ba_next, addr_next, wmask_next, beat_next};
      wdata_reg <= wdata_next;
      open_reg <= open_next;
      {dq_oe_reg, dqs_reg, rd_valid_reg} <= {dq_oe_next, dqs_next, rd_valid_next};
      rbuf_reg <= rbuf_next;
      rd_data_reg <= rd_data_next;
      // read pins come from the device's clock, two stages before use
      dq_s1_reg <= LINK.dq;
      dq_s2_reg <= dq_s1_reg;
      dqs_s1_reg <= LINK.dqs;
      dqs_s2_reg <= dqs_s1_reg;
      dqs_seen_reg <= dqs_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign LINK.ck = ck_reg;
  assign LINK.cke = cke_reg;
  assign LINK.odt = odt_reg;
  assign LINK.cs_n = cs_n_reg;
  assign {LINK.ras_n, LINK.cas_n, LINK.we_n} = cmd_reg[2:0];
  assign LINK.ba = ba_reg;
  assign LINK.addr = addr_reg;
  assign LINK.ctl_dq = wdata_reg[beat_reg * DQ_W +: DQ_W];
  assign LINK.dm = dq_oe_reg && wmask_reg[beat_reg];
  assign LINK.ctl_dq_oe = dq_oe_reg;
  assign LINK.ctl_dqs = dqs_reg;
  assign LINK.ctl_dqs_n = !dqs_reg;
  assign LINK.ctl_dqs_oe = dq_oe_reg;
  assign RD_VALID_O = rd_valid_reg;
  assign RD_DATA_O = rd_data_reg;
endmodule
`default_nettype wire

// >>> drc_link_properties.sv
/*
  Concurrent checks on the pins between the controller and both ranks.
  Assumes instantiation beside the link interface, clocked by its ck and
  disabled while the link-side reset is low.
*/
`timescale 1ns/1ns
`default_nettype none
module drc_link_properties #(
  parameter int DQ_W = 8
) (
  input wire logic ck,
  input wire logic RST_N_I,
  input wire logic [1:0] cke,
  input wire logic [1:0] cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [DQ_W-1:0] dq,
  input wire logic dqs,
  input wire logic dqs_n,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe [2],
  input wire logic dev_dqsn_oe [2]
);
  default clocking cb @(posedge ck); endclocking
  default disable iff (!RST_N_I);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr;
    cs_n != 2'b11 && ras_n && !cas_n && !we_n;
  endsequence
  // rank 0 only decodes with enable high at this and the previous edge
  sequence s_rd0;
    !cs_n[0] && ras_n && !cas_n && we_n && cke[0] && $past(cke[0]);
  endsequence
  sequence s_sr0;
    !cs_n[0] && !ras_n && !cas_n && we_n && !cke[0] && $past(cke[0]);
  endsequence
  sequence s_wr_burst;
    ctl_dq_oe [*4] ##1 !ctl_dq_oe;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  property p_one_rank; cs_n != 2'b00; endproperty
  a_one_rank: assert property (p_one_rank) else $error("both ranks selected");
  property p_no_fight; !(ctl_dq_oe && (dev_dq_oe[0] || dev_dq_oe[1])); endproperty
  a_no_fight: assert property (p_no_fight) else $error("data bus driven by both ends");
  property p_ranks_apart; !(dev_dq_oe[0] && dev_dq_oe[1]); endproperty
  a_ranks_apart: assert property (p_ranks_apart) else $error("both ranks drive data");
  property p_wr_beats; s_wr |=> s_wr_burst; endproperty
  a_wr_beats: assert property (p_wr_beats) else $error("write burst not four beats");
  property p_rd_answer; s_rd0 |-> ##[1:4] dev_dq_oe[0]; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rank_masked; s_rd0 |-> !dev_dq_oe[1] [*8]; endproperty
  a_rank_masked: assert property (p_rank_masked) else $error("unselected rank drove");
  property p_edge_aligned;
    (dev_dq_oe[0] && $past(dev_dq_oe[0]) && dq != $past(dq)) |-> dqs != $past(dqs);
  endproperty
  a_edge_aligned: assert property (p_edge_aligned) else $error("read data moved without strobe");
  property p_dqsn_inv; dev_dqsn_oe[1] |-> dqs_n == !dqs; endproperty
  a_dqsn_inv: assert property (p_dqsn_inv) else $error("complement strobe not inverse");
  property p_sr_quiet; s_sr0 |=> !dev_dq_oe[0] [*8]; endproperty
  a_sr_quiet: assert property (p_sr_quiet) else $error("rank drove in self refresh");
endmodule
`default_nettype wire

// >>> test_ddr2_dual_rank_control_pins.sv
/*
  Self-checking bench: controller joined to both ranks through the link.
  Assumes the controller makes the link clock; the ranks get a later reset
  so they see link clock edges while held.
*/
`timescale 1ns/1ns
`default_nettype none
`include "drc_regs.svh"
module test_ddr2_dual_rank_control_pins;
  logic sys_clk, rst_n, link_rst_n, req_valid, req_ready, req_rank, rd_valid;
  logic [3:0] req_cmd, req_wmask;
  logic [2:0] req_ba;
  logic [14:0] req_addr;
  logic [31:0] req_wdata, rd_data;
  logic [1:0] cke, cke_set, odt;
  logic [1:0] pwr_st [2];
  logic clk_on [2];
  logic term_on [2];
  logic diff_dqs [2];
  logic [7:0] bank_open [2];
  int fails, check_count;

  drc_link_if #(.DQ_W(8)) link ();
  drc_ctrl #(.DQ_W(8)) drc_ctrl_i (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .LINK(link), .REQ_VALID_I(req_valid),
    .REQ_READY_O(req_ready), .REQ_CMD_I(req_cmd), .REQ_RANK_I(req_rank), .REQ_BA_I(req_ba), .REQ_ADDR_I(req_addr),
    .REQ_WDATA_I(req_wdata), .REQ_WMASK_I(req_wmask), .CKE_I(cke), .ODT_I(odt), .RD_VALID_O(rd_valid),
    .RD_DATA_O(rd_data));
  for (genvar r = 0; r < 2; r++) begin : g_rank
    drc_dev #(.RANK(r), .DQ_W(8)) drc_dev_i (.LINK(link), .RST_N_I(link_rst_n), .PWR_STATE_O(pwr_st[r]),
      .CLK_ON_O(clk_on[r]), .TERM_ON_O(term_on[r]), .DIFF_DQS_O(diff_dqs[r]), .BANK_OPEN_O(bank_open[r]));
  end
  drc_link_properties #(.DQ_W(8)) drc_link_properties_i (.ck(link.ck), .RST_N_I(link_rst_n), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .dq(link.dq), .dqs(link.dqs),
    .dqs_n(link.dqs_n), .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe), .dev_dqsn_oe(link.dev_dqsn_oe));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic miss(input string msg);
    fails++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) miss($sformatf("value %h, expected %h", got, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) miss($sformatf("flag %b, expected %b", got, exp));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // enable level goes out with the request so one fall tick carries both
  task automatic req(input logic [3:0] cmd, input logic rank, input logic [2:0] ba, input logic [14:0] addr,
                     input logic [31:0] wd, input logic [3:0] wm);
    int n;
    tick(1);
    n = 0;
    {req_valid, req_cmd, req_rank, req_ba, req_addr, req_wdata, req_wmask} = {1'b1, cmd, rank, ba, addr, wd, wm};
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 200) begin
        miss("request not taken");
        test_done();
      end
      tick(1);
    end
    // set only now: an earlier busy fall tick would send the new level alone
    cke = cke_set;
    tick(1);
    req_valid = 1'b0;
  endtask

  task automatic rd(input logic rank, input logic [31:0] exp);
    int n;
    req(`DRC_CMD_RD, rank, 3'h1, 15'h0000, 32'h0, 4'h0);
    n = 0;
    while (rd_valid !== 1'b1) begin
      n++;
      if (n > 2000) begin
        miss("read never returned");
        test_done();
      end
      tick(1);
    end
    check_data(rd_data, exp);
  endtask

  task automatic wait_pwr(input int r, input logic [1:0] exp);
    int n;
    n = 0;
    while (pwr_st[r] !== exp) begin
      n++;
      if (n > 300) begin
        miss("power state not reached");
        test_done();
      end
      tick(1);
    end
    check_count++;
  endtask

  task automatic set_cke(input logic [1:0] v);
    cke_set = v;
    cke = v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, link_rst_n, req_valid, req_rank, req_ba, req_addr, req_wdata, req_wmask} = '0;
    req_cmd = `DRC_CMD_NOP;
    {cke, cke_set, odt, fails, check_count} = {2'b11, 2'b11, 2'b00, 32'd0, 32'd0};
    tick(6);
    rst_n = 1'b1;
    tick(60);
    link_rst_n = 1'b1;
    tick(40);
    check_bit(diff_dqs[0], 1'b1);
    odt = 2'b11;
    tick(40);
    check_bit(term_on[0], 1'b0);
    req(`DRC_CMD_MRS, 1'b0, 3'h1, 15'h0404, 32'h0, 4'h0);
    req(`DRC_CMD_MRS, 1'b1, 3'h0, 15'h0404, 32'h0, 4'h0);
    tick(40);
    check_bit(term_on[0], 1'b1);
    check_bit(term_on[1], 1'b0);
    check_bit(diff_dqs[0], 1'b0);
    odt = 2'b10;
    tick(40);
    check_bit(term_on[0], 1'b0);
    req(`DRC_CMD_ACT, 1'b0, 3'h1, 15'h0000, 32'h0, 4'h0);
    tick(40);
    check_data({bank_open[1], bank_open[0]}, 32'h0000_0002);
    req(`DRC_CMD_WR, 1'b0, 3'h1, 15'h0000, 32'h4433_2211, 4'h0);
    req(`DRC_CMD_WR, 1'b0, 3'h1, 15'h0000, 32'hDDCC_BBAA, 4'h2);
    req(`DRC_CMD_ACT, 1'b1, 3'h1, 15'h0000, 32'h0, 4'h0);
    req(`DRC_CMD_WR, 1'b1, 3'h1, 15'h0000, 32'h8765_4321, 4'h0);
    rd(1'b0, 32'hDDCC_22AA);
    rd(1'b1, 32'h8765_4321);
    req(`DRC_CMD_PRE, 1'b1, 3'h0, 15'h0400, 32'h0, 4'h0);
    set_cke(2'b00);
    wait_pwr(0, drc_pkg::DRC_PWR_PD_ACT);
    wait_pwr(1, drc_pkg::DRC_PWR_PD_PRE);
    check_bit(clk_on[0], 1'b0);
    odt = 2'b11;
    tick(40);
    check_bit(term_on[0], 1'b1);
    set_cke(2'b11);
    wait_pwr(0, drc_pkg::DRC_PWR_ACTIVE);
    check_bit(clk_on[1], 1'b1);
    req(`DRC_CMD_PRE, 1'b0, 3'h0, 15'h0400, 32'h0, 4'h0);
    cke_set = 2'b10;
    req(`DRC_CMD_REF, 1'b0, 3'h0, 15'h0000, 32'h0, 4'h0);
    wait_pwr(0, drc_pkg::DRC_PWR_SREF);
    check_bit(clk_on[0], 1'b0);
    check_bit(term_on[0], 1'b0);
    req(`DRC_CMD_ACT, 1'b1, 3'h1, 15'h0000, 32'h0, 4'h0);
    rd(1'b1, 32'h8765_4321);
    set_cke(2'b11);
    wait_pwr(0, drc_pkg::DRC_PWR_ACTIVE);
    req(`DRC_CMD_ACT, 1'b0, 3'h1, 15'h0000, 32'h0, 4'h0);
    rd(1'b0, 32'hDDCC_22AA);
    test_done();
  end
endmodule
`default_nettype wire
